// ==== design/tsq_sequencer.sv ====
// Top-level radio sequencer: listen and beacon duty cycling driven by two
// interval timers, a receive timeout and radio events. Assumes events are
// synchronous single-cycle pulses from the datapath on the same clock.
// Notes on behaviour
// - Preamble listen wakes every first_interval_timer+second_interval_timer, receives for second_interval_timer.
// - No preamble in the window: back to idle, sleep with RC only.
// - Preamble found in preamble listen turns sequencer off, stays receiving.
// - Receive exit route 110 stops sequencer on preamble found.
// - Second_interval_timer bounds receive time while no preamble is seen.
// - First_interval_timer plus second_interval_timer sets period between polling starts.
// - Sync listen wakes for receive timeout, low power for the rest.
// - Preamble before receive timeout keeps receiving, waiting for sync.
// - No sync by second_interval_timer end resumes polling; timeout route 10 to low power.
// - Sync match raises event, stops sequencer, stays receiving.
// - Receive exit route 101 stops sequencer on sync match.
// - Beacon transmits every first_interval_timer+second_interval_timer, back to idle after packet sent.
// - Transmit exit route 0 goes to low power on packet sent.
// - Beacon loops forever until host sets the stop bit.
// - Beacon enable resends the unchanged payload periodically.
`timescale 1ns/1ps

module tsq_sequencer
    import tsq_pkg::*;
#(
    parameter int TICK = TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Radio events
    input wire tsq_pkg::tsq_event_type events,
    // Mode requests and beacon reload
    output tsq_pkg::tsq_mode_type mode,
    output logic payload_reload,
    // Event pins
    output logic event_pin_4,
    output logic event_pin_2
);
    import tsq_pkg::*;

    logic [2:0] seq_config;
    logic [31:0] routes;
    logic [15:0] first_interval_timer;
    logic [15:0] second_interval_timer;
    logic [15:0] preamble_receive_timeout;
    logic beacon_enable;
    logic [2:0] event_map;
    tsq_state_type state;
    tsq_state_type next_state;
    logic [15:0] tick_count;
    logic tick;
    logic [15:0] t_count;
    logic [15:0] rx_count;
    logic in_second_interval_timer;
    logic preamble_seen;
    logic sync_flag;
    logic preamble_flag;
    logic bus_req;
    logic start_pulse;
    logic stop_pulse;
    logic timer_done;
    logic rx_to_done;
    logic bus_write;
    logic bus_read;
    logic config_write;
    logic status_read;

    wire [1:0] start_exit_route = routes[ROUTE_START_LSB +: 2];
    wire low_power_route = routes[ROUTE_LOW_POWER_BIT];
    wire idle_exit_route = routes[ROUTE_IDLE_BIT];
    wire [2:0] receive_exit_route = routes[ROUTE_RECEIVE_LSB +: 3];
    wire [1:0] rx_timeout_exit_route = routes[ROUTE_RX_TIMEOUT_LSB +: 2];
    wire transmit_exit_route = routes[ROUTE_TRANSMIT_BIT];
    wire idle_state_select = seq_config[SEQ_IDLE_SEL_BIT];

    // Byte-lane merge for a 32-bit register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Low half of a 16-bit register behind the two low byte lanes
    function automatic logic [15:0] merge_half(input logic [15:0] old, input logic [31:0] val, input logic [3:0] sel);
        logic [31:0] res;
        res = merge({16'h0, old}, val, sel);
        return res[15:0];
    endfunction

    // One timer unit off a down-counter that rests at zero
    function automatic logic [15:0] count_down(input logic [15:0] count, input logic step);
        return (step && count != 16'h0) ? count - 16'h1 : count;
    endfunction

    // Idle and low power both leave the radio in its idle state
    function automatic logic is_resting(input tsq_state_type s);
        return s == TSQ_IDLE || s == TSQ_LOW_POWER;
    endfunction

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_write = bus_req && wb_we_i;
    assign bus_read = bus_req && !wb_we_i;
    // The triggers and the flag clear share one decode each
    assign config_write = bus_write && wb_adr_i == ADDR_SEQ_CONFIG && wb_sel_i[0];
    assign status_read = bus_read && wb_adr_i == ADDR_STATUS;
    assign start_pulse = config_write && wb_dat_i[SEQ_START_BIT];
    assign stop_pulse = config_write && wb_dat_i[SEQ_STOP_BIT];

    // Ack one cycle after the request, dropped the next cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            seq_config <= 3'h0;
            routes <= RESET_ROUTES;
            first_interval_timer <= RESET_TIMER;
            second_interval_timer <= RESET_TIMER;
            preamble_receive_timeout <= RESET_RX_TIMEOUT;
            beacon_enable <= 1'b0;
            event_map <= 3'h0;
        end else if (bus_write) begin
            case (wb_adr_i)
                ADDR_SEQ_CONFIG: begin
                    // Start and stop bits are self-clearing triggers
                    if (wb_sel_i[0]) begin
                        seq_config <= {wb_dat_i[SEQ_IDLE_SEL_BIT], 2'b00};
                    end
                end
                ADDR_ROUTES: routes <= merge(routes, wb_dat_i, wb_sel_i);
                ADDR_FIRST_INTERVAL_TIMER: first_interval_timer <= merge_half(first_interval_timer, wb_dat_i, wb_sel_i);
                ADDR_SECOND_INTERVAL_TIMER: second_interval_timer <= merge_half(second_interval_timer, wb_dat_i, wb_sel_i);
                ADDR_RX_TIMEOUT: preamble_receive_timeout <= merge_half(preamble_receive_timeout, wb_dat_i, wb_sel_i);
                ADDR_PACKET_CONFIG: begin
                    if (wb_sel_i[0]) begin
                        beacon_enable <= wb_dat_i[PKT_BEACON_BIT];
                    end
                end
                ADDR_EVENT_MAP: begin
                    if (wb_sel_i[0]) begin
                        event_map <= wb_dat_i[2:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Read data registered with the ack; unmapped reads return zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wb_dat_o <= 32'h0;
        end else if (bus_read) begin
            case (wb_adr_i)
                ADDR_SEQ_CONFIG: wb_dat_o <= {29'h0, seq_config};
                ADDR_ROUTES: wb_dat_o <= routes;
                ADDR_FIRST_INTERVAL_TIMER: wb_dat_o <= {16'h0, first_interval_timer};
                ADDR_SECOND_INTERVAL_TIMER: wb_dat_o <= {16'h0, second_interval_timer};
                ADDR_RX_TIMEOUT: wb_dat_o <= {16'h0, preamble_receive_timeout};
                ADDR_PACKET_CONFIG: wb_dat_o <= {31'h0, beacon_enable};
                ADDR_EVENT_MAP: wb_dat_o <= {29'h0, event_map};
                ADDR_STATUS: wb_dat_o <= {27'h0, sync_flag, preamble_flag, state};
                default: wb_dat_o <= 32'h0;
            endcase
        end else begin
            wb_dat_o <= 32'h0;
        end
    end

    // Prescaler: one tick per timer unit
    // Restarted while off so the first idle wait spans whole units
    always_ff @(posedge clk) begin
        if (!reset_n || state == TSQ_OFF || tick) begin
            tick_count <= 16'h0;
        end else begin
            tick_count <= tick_count + 16'h1;
        end
    end
    assign tick = (tick_count == 16'(TICK - 1));

    // Interval timer: first_interval_timer then second_interval_timer, free of the state so the period stays first_interval_timer + second_interval_timer
    assign timer_done = tick && (t_count <= 16'h1);
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            t_count <= 16'h0;
            in_second_interval_timer <= 1'b0;
        end else if (state == TSQ_OFF) begin
            // Armed with first_interval_timer so a start spends first_interval_timer in idle first
            t_count <= first_interval_timer;
            in_second_interval_timer <= 1'b0;
        end else if (timer_done && in_second_interval_timer) begin
            // Second_interval_timer hands back to first_interval_timer wherever the sequencer is, so a receive timeout keeps the period
            t_count <= first_interval_timer;
            in_second_interval_timer <= 1'b0;
        end else if (timer_done) begin
            t_count <= second_interval_timer;
            in_second_interval_timer <= 1'b1;
        end else begin
            t_count <= count_down(t_count, tick);
        end
    end

    // Receive timeout counter, disarmed (not cleared) when a preamble is seen
    // A preamble in the very cycle of the last unit still counts as heard
    assign rx_to_done = tick && rx_count == 16'h1 && !preamble_seen && !events.preamble_found_event;
    always_ff @(posedge clk) begin
        if (!reset_n || state != TSQ_RECEIVE) begin
            rx_count <= preamble_receive_timeout;
            preamble_seen <= 1'b0;
        end else begin
            if (events.preamble_found_event) begin
                preamble_seen <= 1'b1;
            end
            rx_count <= count_down(rx_count, tick);
        end
    end

    // Sticky event flags, cleared by reading status; a set in the same cycle wins
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync_flag <= 1'b0;
            preamble_flag <= 1'b0;
        end else begin
            if (events.sync_match_event) begin
                sync_flag <= 1'b1;
            end else if (status_read) begin
                sync_flag <= 1'b0;
            end
            if (events.preamble_found_event) begin
                preamble_flag <= 1'b1;
            end else if (status_read) begin
                preamble_flag <= 1'b0;
            end
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            TSQ_OFF: begin
                if (start_pulse && start_exit_route == START_TO_LOW_POWER) begin
                    next_state = TSQ_LOW_POWER;
                end
            end
            TSQ_LOW_POWER: begin
                // Low power selection: route 1 goes to idle, route 0 turns the sequencer off
                next_state = low_power_route ? TSQ_IDLE : TSQ_OFF;
            end
            TSQ_IDLE: begin
                // Second_interval_timer ending here only rearms first_interval_timer; idle is left on first_interval_timer alone
                if (timer_done && !in_second_interval_timer) begin
                    next_state = idle_exit_route ? TSQ_RECEIVE : TSQ_TRANSMIT;
                end
            end
            TSQ_RECEIVE: begin
                if (receive_exit_route == RX_EXIT_ON_PREAMBLE_OFF && events.preamble_found_event) begin
                    next_state = TSQ_OFF;
                end else if (receive_exit_route == RX_EXIT_ON_SYNC_OFF && events.sync_match_event) begin
                    next_state = TSQ_OFF;
                end else if (rx_to_done && rx_timeout_exit_route == RXTO_TO_LOW_POWER) begin
                    next_state = TSQ_LOW_POWER;
                end else if (timer_done && in_second_interval_timer) begin
                    next_state = TSQ_LOW_POWER;
                end
            end
            TSQ_TRANSMIT: begin
                // Other transmit routes are not built; the sequencer then waits for a stop write
                if (events.packet_sent_event && !transmit_exit_route) begin
                    next_state = TSQ_LOW_POWER;
                end
            end
            default: next_state = TSQ_OFF;
        endcase
        if (stop_pulse) begin
            next_state = TSQ_OFF;
        end
    end

    // Receive is kept after the sequencer stops on an event until the host switches modes
    logic hold_rx;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= TSQ_OFF;
            hold_rx <= 1'b0;
        end else begin
            state <= next_state;
            if (start_pulse || stop_pulse) begin
                hold_rx <= 1'b0;
            end else if (state == TSQ_RECEIVE && next_state == TSQ_OFF) begin
                hold_rx <= 1'b1;
            end
        end
    end

    // A start or stop write releases the held receive at once
    logic next_rx_hold;
    assign next_rx_hold = !start_pulse && !stop_pulse && (hold_rx || state == TSQ_RECEIVE);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode <= '0;
            payload_reload <= 1'b0;
            event_pin_4 <= 1'b0;
            event_pin_2 <= 1'b0;
        end else begin
            mode.rx_on <= (next_state == TSQ_RECEIVE) || (next_state == TSQ_OFF && next_rx_hold);
            mode.tx_on <= (next_state == TSQ_TRANSMIT);
            mode.sleep <= is_resting(next_state) && idle_state_select;
            mode.standby <= is_resting(next_state) && !idle_state_select;
            // Payload kept in the buffer is rearmed for each beacon
            payload_reload <= beacon_enable && state == TSQ_TRANSMIT && next_state != TSQ_TRANSMIT;
            event_pin_4 <= events.preamble_found_event && event_map[MAP_PIN4_LSB +: 2] == PIN4_PREAMBLE_MAP &&
                event_map[MAP_PREAMBLE_EN_BIT];
            event_pin_2 <= events.sync_match_event;
        end
    end

endmodule

// ==== design/tsq_pkg.sv ====
// Package for the top-level radio sequencer: register map, field layout,
// route encodings and timer units. Assumes a 32-bit classic Wishbone slave.
package tsq_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_SEQ_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_ROUTES = 8'h04;
    localparam logic [7:0] ADDR_FIRST_INTERVAL_TIMER = 8'h08;
    localparam logic [7:0] ADDR_SECOND_INTERVAL_TIMER = 8'h0c;
    localparam logic [7:0] ADDR_RX_TIMEOUT = 8'h10;
    localparam logic [7:0] ADDR_PACKET_CONFIG = 8'h14;
    localparam logic [7:0] ADDR_EVENT_MAP = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;

    // Sequencer config field positions
    localparam int SEQ_START_BIT = 0;
    localparam int SEQ_STOP_BIT = 1;
    localparam int SEQ_IDLE_SEL_BIT = 2;

    // Route register field positions
    localparam int ROUTE_START_LSB = 0;
    localparam int ROUTE_LOW_POWER_BIT = 2;
    localparam int ROUTE_IDLE_BIT = 3;
    localparam int ROUTE_RECEIVE_LSB = 4;
    localparam int ROUTE_RX_TIMEOUT_LSB = 7;
    localparam int ROUTE_TRANSMIT_BIT = 9;

    // Packet config and event map field positions
    localparam int PKT_BEACON_BIT = 0;
    localparam int MAP_PIN4_LSB = 0;
    localparam int MAP_PREAMBLE_EN_BIT = 2;

    // Reset values
    localparam logic [31:0] RESET_ROUTES = 32'h0000_0000;
    localparam logic [15:0] RESET_TIMER = 16'h0001;
    localparam logic [15:0] RESET_RX_TIMEOUT = 16'h0000;

    // Route encodings
    localparam logic [2:0] RX_EXIT_ON_SYNC_OFF = 3'h5;
    localparam logic [2:0] RX_EXIT_ON_PREAMBLE_OFF = 3'h6;
    localparam logic [1:0] RXTO_TO_LOW_POWER = 2'h2;
    localparam logic [1:0] START_TO_LOW_POWER = 2'h0;
    localparam logic [1:0] PIN4_PREAMBLE_MAP = 2'h3;

    // Timer tick: 64 us per timer count at 40 MHz
    localparam int CLK_HZ = 40_000_000;
    localparam int TIMER_TICK_US = 64;
    localparam int TICK_CYCLES = (TIMER_TICK_US * (CLK_HZ / 1_000_000));

    typedef enum logic [2:0] {
        TSQ_OFF = 3'b000,
        TSQ_IDLE = 3'b001,
        TSQ_RECEIVE = 3'b010,
        TSQ_TRANSMIT = 3'b011,
        TSQ_LOW_POWER = 3'b100
    } tsq_state_type;

    // Events from the radio datapath
    typedef struct packed {
        logic preamble_found_event;
        logic sync_match_event;
        logic packet_sent_event;
    } tsq_event_type;

    // Mode requests toward the radio datapath
    typedef struct packed {
        logic rx_on;
        logic tx_on;
        logic sleep;
        logic standby;
    } tsq_mode_type;

endpackage

// ==== testbench/tsq_checker.sv ====
// Port-level checks for the sequencer, bound into the design.
// Assumes full-word route writes; the route fields are shadowed from the bus.
`timescale 1ns/1ps

module tsq_checker
    import tsq_pkg::*;
#(
    parameter int TICK = TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Radio side
    input wire tsq_pkg::tsq_event_type events,
    input wire tsq_pkg::tsq_mode_type mode,
    input wire logic payload_reload,
    input wire logic event_pin_4,
    input wire logic event_pin_2
);
    logic [9:0] routes;
    logic taken;
    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Exit conditions depend on the programmed routes, so keep a copy
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            routes <= 10'h000;
        end else if (taken && wb_we_i && wb_adr_i == ADDR_ROUTES) begin
            routes <= wb_dat_i[9:0];
        end
    end
    a_ack_latency: assert property (taken |=> wb_ack_o) else $error("ack late");
    a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
    a_pin2_sync: assert property (events.sync_match_event |=> event_pin_2)
        else $error("pin 2 missed sync");
    a_pin4_cause: assert property (event_pin_4 |-> $past(events.preamble_found_event))
        else $error("pin 4 without preamble");
    a_preamble_held: assert property (mode.rx_on && events.preamble_found_event
        && routes[6:4] == RX_EXIT_ON_PREAMBLE_OFF |=> mode.rx_on [*8]) else $error("rx dropped after preamble");
    a_sync_held: assert property (mode.rx_on && events.sync_match_event
        && routes[6:4] == RX_EXIT_ON_SYNC_OFF |=> mode.rx_on [*8]) else $error("rx dropped after sync");
    a_tx_end: assert property (mode.tx_on && events.packet_sent_event && !routes[ROUTE_TRANSMIT_BIT]
        |-> ##[1:2] !mode.tx_on) else $error("tx held after packet sent");
    a_stop_off: assert property (taken && wb_we_i && wb_adr_i == ADDR_SEQ_CONFIG && wb_dat_i[SEQ_STOP_BIT]
        |-> ##[1:3] mode == 4'h0) else $error("stop ignored");
    c_rx_wake: cover property ($rose(mode.rx_on));
    c_tx_wake: cover property ($rose(mode.tx_on));
    c_reload: cover property (payload_reload);
endmodule

bind tsq_sequencer tsq_checker #(.TICK(TICK)) i_tsq_checker (
    .clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .events(events), .mode(mode), .payload_reload(payload_reload), .event_pin_4(event_pin_4),
    .event_pin_2(event_pin_2)
);

// ==== testbench/tsq_radio_model.sv ====
// Behavioural radio datapath: answers mode requests with event pulses.
// Assumes the bench sets the channel controls between receive windows.
`timescale 1ns/1ps

module tsq_radio_model
    import tsq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Mode requests and channel controls
    input wire tsq_pkg::tsq_mode_type mode,
    input wire logic signal_on,
    input wire logic sync_on,
    input wire logic [7:0] delay,
    // Event pulses
    output tsq_pkg::tsq_event_type events
);
    logic [7:0] cnt;
    logic found;
    always_ff @(posedge clk) begin
        cnt <= (reset_n && (mode.rx_on || mode.tx_on)) ? cnt + 8'h01 : 8'h00;
        found <= reset_n && mode.rx_on && (found || events.preamble_found_event);
    end
    // A sync word only follows a preamble heard in the same window
    always_ff @(posedge clk) begin
        events.packet_sent_event <= reset_n && mode.tx_on && cnt == delay;
        events.preamble_found_event <= reset_n && mode.rx_on && signal_on && cnt == delay;
        events.sync_match_event <= reset_n && mode.rx_on && sync_on && found && cnt == delay + 8'h03;
    end
endmodule

// ==== testbench/tb_tsq_sequencer.sv ====
// Bench for the radio sequencer: registers, both listen modes, beacon.
// Assumes the radio model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module tb_tsq_sequencer;
    import tsq_pkg::*;
    localparam int TK = 4;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, got;
    logic ack, reload, pin4, pin2;
    logic sig_on = 1'b0;
    logic sync_on = 1'b0;
    logic [7:0] delay = 8'h02;
    logic [31:0] seed = 32'h9c5d5a0f;
    tsq_event_type events;
    tsq_mode_type mode;
    int fail_count = 0;
    int samples_checked = 0;
    int reloads = 0;

    tsq_sequencer #(.TICK(TK)) i_tsq_sequencer (
        .clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .events(events), .mode(mode),
        .payload_reload(reload), .event_pin_4(pin4), .event_pin_2(pin2)
    );
    tsq_radio_model i_tsq_radio_model (
        .clk(clk), .reset_n(reset_n), .mode(mode), .signal_on(sig_on), .sync_on(sync_on), .delay(delay),
        .events(events)
    );

    always #12.5 clk = ~clk;
    always @(posedge clk) reloads <= reloads + int'(reload === 1'b1);

    function automatic int rnd(input int lo, input int span);
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return lo + int'(seed[7:0]) % span;
    endfunction

    function automatic logic pick(input int sel);
        return sel == 0 ? mode.rx_on : sel == 1 ? mode.tx_on : sel == 2 ? pin4 : pin2;
    endfunction

    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Durations allow two cycles of slack for state hand-over edges
    task automatic chk_span(input string what, input int exp, input int seen);
        samples_checked++;
        if (seen < exp - 2 || seen > exp + 2) begin
            fail_count++;
            $display("ERROR %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        chk("bus ack", 32'h1, 32'(ack));
        got = rdat;
        cyc <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, exp, got);
    endtask

    task automatic wait_on(input int sel, input logic val, input int lim, output int n);
        n = 0;
        while (pick(sel) !== val && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask

    // Times one high phase of the chosen signal and the span to its next rise
    task automatic measure(input int sel, output int dur, output int per);
        int n;
        wait_on(sel, 1'b1, 2000, n);
        wait_on(sel, 1'b0, 2000, dur);
        wait_on(sel, 1'b1, 2000, n);
        per = dur + n;
    endtask

    task automatic setup(input logic [31:0] routes, input int t1, input int t2, input int rxto);
        bus(1'b1, ADDR_FIRST_INTERVAL_TIMER, 32'(t1));
        bus(1'b1, ADDR_SECOND_INTERVAL_TIMER, 32'(t2));
        bus(1'b1, ADDR_RX_TIMEOUT, 32'(rxto));
        bus(1'b1, ADDR_ROUTES, routes);
        rd_chk("second_interval_timer", ADDR_SECOND_INTERVAL_TIMER, 32'(t2));
        bus(1'b1, ADDR_SEQ_CONFIG, 32'h5);
    endtask

    task automatic stop_seq;
        bus(1'b1, ADDR_SEQ_CONFIG, 32'h6);
        repeat (3) @(posedge clk);
        chk("stopped", 32'h0, 32'(mode));
        sig_on <= 1'b0;
        sync_on <= 1'b0;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_of_test();
    end

    initial begin
        int t1, t2, d, p, n;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd_chk("routes", ADDR_ROUTES, RESET_ROUTES);
        rd_chk("first_interval_timer", ADDR_FIRST_INTERVAL_TIMER, 32'(RESET_TIMER));
        rd_chk("unmapped", 8'h20, 32'h0);
        // Preamble listen on a quiet channel
        t1 = rnd(2, 3);
        t2 = rnd(3, 3);
        setup(32'h6c, t1, t2, 0);
        wait_on(0, 1'b1, 2000, n);
        chk_span("first wake", t1 * TK - 1, n);
        measure(0, d, p);
        chk_span("rx window", t2 * TK - 1, d);
        chk_span("poll period", (t1 + t2) * TK, p);
        wait_on(0, 1'b0, 2000, n);
        repeat (4) @(posedge clk);
        chk("idle mode", 32'h2, 32'(mode));
        stop_seq();
        // Preamble heard: sequencer stops with receive held
        bus(1'b1, ADDR_EVENT_MAP, 32'h7);
        delay <= 8'(rnd(2, 4));
        sig_on <= 1'b1;
        setup(32'h6c, t1, t2, 0);
        wait_on(2, 1'b1, 2000, n);
        chk("pin 4 event", 32'h1, 32'(n < 2000));
        repeat (2 * (t1 + t2) * TK) @(posedge clk);
        chk("held rx", 32'h1, 32'(mode.rx_on));
        rd_chk("status preamble", ADDR_STATUS, 32'h8);
        rd_chk("status cleared", ADDR_STATUS, 32'h0);
        stop_seq();
        // Sync listen: shortest first timer, timeout of two ticks
        t2 = rnd(5, 3);
        delay <= 8'h02;
        setup(32'h15c, 1, t2, 2);
        measure(0, d, p);
        chk_span("timeout window", 2 * TK - 1, d);
        chk_span("sync period", (1 + t2) * TK, p);
        sig_on <= 1'b1;
        measure(0, d, p);
        chk_span("no sync window", t2 * TK - 1, d);
        chk_span("poll resumes", (1 + t2) * TK, p);
        sig_on <= 1'b0;
        sync_on <= 1'b1;
        measure(0, d, p);
        rd_chk("status rx", ADDR_STATUS, 32'ha);
        repeat (2) @(posedge clk);
        sig_on <= 1'b1;
        wait_on(3, 1'b1, 2000, n);
        chk("pin 2 event", 32'h1, 32'(n < 2000));
        repeat (2 * (1 + t2) * TK) @(posedge clk);
        chk("sync held rx", 32'h1, 32'(mode.rx_on));
        rd_chk("status sync", ADDR_STATUS, 32'h18);
        stop_seq();
        // Beacon: three unattended transmissions, then stop
        bus(1'b1, ADDR_PACKET_CONFIG, 32'h1);
        delay <= 8'(rnd(3, 4));
        t1 = rnd(2, 2);
        setup(32'h04, t1, 2, 0);
        n = reloads;
        for (int i = 0; i < 3; i++) begin
            measure(1, d, p);
            chk_span("tx time", int'(delay) + 2, d);
            chk_span("beacon period", (t1 + 2) * TK, p);
        end
        chk("reloads", 32'h3, 32'(reloads - n));
        stop_seq();
        wait_on(1, 1'b1, 4 * (t1 + 2) * TK, n);
        chk("quiet after stop", 32'(4 * (t1 + 2) * TK), 32'(n));
        end_of_test();
    end
endmodule
